//--- hdl/sie_host_irq_enable.sv
// Host interrupt enable bits for the serial interrupt link, with Avalon-MM slave
// What this block does
// [R1] Direct off: SMI needs ch2 enable and full
// [R2] Direct on: ch2 SMI enable alone requests SMI
// [R3] SMI enable clears: write 0, reset, full drop unless direct mode
// [R4] SMI enable sets: write 1 after reading 0
// [R5] IRQ12 needs ch1 enable and ch1 full
// [R6] IRQ12 enable clears: write 0, reset, full drop
// [R7] IRQ12 enable sets: write 1 after reading 0
// [R8] IRQ1 needs ch1 enable and ch1 full
// [R9] IRQ1 enable clears: write 0, reset, full drop
// [R10] IRQ1 enable sets: write 1 after reading 0
// [R11] Direct off: IRQ11 needs ch3 enable and full
// [R12] Direct on: ch3 IRQ11 enable alone requests
// [R13] IRQ11 enable clears: write 0, reset, full drop unless direct mode
// [R14] IRQ11 enable sets: write 1 after reading 0
// [R15] Ch2/ch3 gate on full unless direct mode
// [R16] Enables reset to 0, local access only
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module sie_host_irq_enable (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire sie_pkg::sie_link_type link_pins,
  output sie_pkg::sie_host_req_type host_req,
  output sie_pkg::sie_out_data_type host_data,
  output logic irq
);

  typedef struct packed {
    sie_pkg::sie_bus_state_type bus;
    logic [7:0] rdata;
    logic irq1_enable_ch1;
    logic irq12_enable_ch1;
    logic smi_enable_ch2;
    logic irq11_enable_ch3;
    logic direct_irq_mode;
    logic [3:0] armed;
    logic out_full_ch1;
    logic out_full_ch2;
    logic out_full_ch3a;
    sie_pkg::sie_out_data_type data;
    logic [sie_pkg::SIE_EVT_W-1:0] evt_status;
    logic [sie_pkg::SIE_EVT_W-1:0] evt_mask;
    logic lclk_prev;
    sie_pkg::sie_host_req_type req;
    logic irq;
  } sie_state_type;

  sie_state_type q;
  sie_state_type n;
  sie_pkg::sie_link_type link_s;
  // Reset pin idles high; flopped inverted so a cleared synchroniser reads idle
  sie_pkg::sie_link_type link_flip;
  sie_pkg::sie_link_type link_sq;

  logic lpc_reset;
  logic lclk_rise;
  logic take_ch1;
  logic take_ch2;
  logic take_ch3;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] wbyte;

  // Enable bit update: write 0 clears, write 1 sets only when armed by a zero read
  function automatic logic en_write(input logic cur, input logic wbit, input logic armed);
    logic r;
    r = cur;
    if (!wbit) begin
      r = 1'b0;
    end else if (armed) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // Request level: full flag gates unless direct mode
  function automatic logic req_level(input logic en, input logic direct, input logic full);
    return en && (direct || full);
  endfunction

  // Pins arrive from the LPC side, so they are synchronised first
  sie_sync #(
    .W(sie_pkg::SIE_LINK_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .d(link_flip),
    .q(link_sq)
  );

  always_comb begin
    link_flip = link_pins;
    link_flip.lpc_rst_n = !link_pins.lpc_rst_n;
    link_s = link_sq;
    link_s.lpc_rst_n = !link_sq.lpc_rst_n;
  end

  assign rd_ok = avs_read && (q.bus == sie_pkg::SIE_BUS_ACK) && ce;
  assign wr_ok = avs_write && (q.bus == sie_pkg::SIE_BUS_ACK) && ce && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign lpc_reset = !link_s.lpc_rst_n || link_s.lpc_swrst;
  // Host read strobes are only meaningful on an LPC clock rising edge
  assign lclk_rise = link_s.lpc_clk && !q.lclk_prev;
  assign take_ch1 = lclk_rise && link_s.host_rd_ch1 && q.out_full_ch1;
  assign take_ch2 = lclk_rise && link_s.host_rd_ch2 && q.out_full_ch2;
  assign take_ch3 = lclk_rise && link_s.host_rd_ch3 && q.out_full_ch3a;

  always_comb begin
    n = q;
    n.lclk_prev = link_s.lpc_clk;

    // Bus handshake; read data is captured one cycle before it is presented
    case (q.bus)
      sie_pkg::SIE_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          n.bus = sie_pkg::SIE_BUS_ACK;
          n.rdata = 8'h00;
          case (avs_address)
            sie_pkg::SIE_ADDR_CTRL0: begin
              n.rdata[sie_pkg::SIE_BIT_IRQ1_EN] = q.irq1_enable_ch1;
              n.rdata[sie_pkg::SIE_BIT_IRQ12_EN] = q.irq12_enable_ch1;
              n.rdata[sie_pkg::SIE_BIT_SMI_EN] = q.smi_enable_ch2;
              n.rdata[sie_pkg::SIE_BIT_DIRECT] = q.direct_irq_mode;
            end
            sie_pkg::SIE_ADDR_CTRL1: begin
              n.rdata[sie_pkg::SIE_BIT_IRQ11_EN] = q.irq11_enable_ch3;
            end
            sie_pkg::SIE_ADDR_DATA_CH1: begin
              n.rdata = q.data.ch1;
            end
            sie_pkg::SIE_ADDR_DATA_CH2: begin
              n.rdata = q.data.ch2;
            end
            sie_pkg::SIE_ADDR_DATA_CH3: begin
              n.rdata = q.data.ch3;
            end
            sie_pkg::SIE_ADDR_FLAGS: begin
              n.rdata[sie_pkg::SIE_BIT_FULL_CH1] = q.out_full_ch1;
              n.rdata[sie_pkg::SIE_BIT_FULL_CH2] = q.out_full_ch2;
              n.rdata[sie_pkg::SIE_BIT_FULL_CH3A] = q.out_full_ch3a;
            end
            sie_pkg::SIE_ADDR_EVT_STATUS: begin
              n.rdata[sie_pkg::SIE_EVT_W-1:0] = q.evt_status;
            end
            sie_pkg::SIE_ADDR_EVT_MASK: begin
              n.rdata[sie_pkg::SIE_EVT_W-1:0] = q.evt_mask;
            end
            default: begin
              n.rdata = 8'h00;
            end
          endcase
        end
      end
      sie_pkg::SIE_BUS_ACK: begin
        n.bus = sie_pkg::SIE_BUS_IDLE;
      end
      default: begin
        n.bus = sie_pkg::SIE_BUS_IDLE;
      end
    endcase

    // A completed read arms each enable bit that read back as 0
    if (rd_ok && avs_address == sie_pkg::SIE_ADDR_CTRL0) begin
      n.armed[sie_pkg::SIE_ARM_IRQ1] = !q.rdata[sie_pkg::SIE_BIT_IRQ1_EN];
      n.armed[sie_pkg::SIE_ARM_IRQ12] = !q.rdata[sie_pkg::SIE_BIT_IRQ12_EN];
      n.armed[sie_pkg::SIE_ARM_SMI] = !q.rdata[sie_pkg::SIE_BIT_SMI_EN];
    end
    if (rd_ok && avs_address == sie_pkg::SIE_ADDR_CTRL1) begin
      n.armed[sie_pkg::SIE_ARM_IRQ11] = !q.rdata[sie_pkg::SIE_BIT_IRQ11_EN];
    end

    // Only the local bus reaches these bits; the host has no path here
    if (wr_ok) begin // R16
      case (avs_address)
        sie_pkg::SIE_ADDR_CTRL0: begin
          n.irq1_enable_ch1 = en_write(q.irq1_enable_ch1, wbyte[sie_pkg::SIE_BIT_IRQ1_EN],
            q.armed[sie_pkg::SIE_ARM_IRQ1]); // R9 R10
          n.irq12_enable_ch1 = en_write(q.irq12_enable_ch1, wbyte[sie_pkg::SIE_BIT_IRQ12_EN],
            q.armed[sie_pkg::SIE_ARM_IRQ12]); // R6 R7
          n.smi_enable_ch2 = en_write(q.smi_enable_ch2, wbyte[sie_pkg::SIE_BIT_SMI_EN],
            q.armed[sie_pkg::SIE_ARM_SMI]); // R3 R4
          n.direct_irq_mode = wbyte[sie_pkg::SIE_BIT_DIRECT];
          n.armed[sie_pkg::SIE_ARM_SMI:sie_pkg::SIE_ARM_IRQ1] = 3'h0;
        end
        sie_pkg::SIE_ADDR_CTRL1: begin
          n.irq11_enable_ch3 = en_write(q.irq11_enable_ch3, wbyte[sie_pkg::SIE_BIT_IRQ11_EN],
            q.armed[sie_pkg::SIE_ARM_IRQ11]); // R13 R14
          n.armed[sie_pkg::SIE_ARM_IRQ11] = 1'b0;
        end
        sie_pkg::SIE_ADDR_EVT_MASK: begin
          n.evt_mask = wbyte[sie_pkg::SIE_EVT_W-1:0];
        end
        default: begin
          n.evt_mask = q.evt_mask;
        end
      endcase
    end

    // Host read empties a channel; a same-cycle local write keeps it full
    if (take_ch1) begin
      n.out_full_ch1 = 1'b0;
    end
    if (take_ch2) begin
      n.out_full_ch2 = 1'b0;
    end
    if (take_ch3) begin
      n.out_full_ch3a = 1'b0;
    end
    if (wr_ok && avs_address == sie_pkg::SIE_ADDR_DATA_CH1) begin
      n.data.ch1 = wbyte;
      n.out_full_ch1 = 1'b1;
    end
    if (wr_ok && avs_address == sie_pkg::SIE_ADDR_DATA_CH2) begin
      n.data.ch2 = wbyte;
      n.out_full_ch2 = 1'b1;
    end
    if (wr_ok && avs_address == sie_pkg::SIE_ADDR_DATA_CH3) begin
      n.data.ch3 = wbyte;
      n.out_full_ch3a = 1'b1;
    end

    // Full flag dropping clears the enables; ch2 and ch3 only outside direct mode
    if (q.out_full_ch1 && !n.out_full_ch1) begin
      n.irq1_enable_ch1 = 1'b0; // R9
      n.irq12_enable_ch1 = 1'b0; // R6
    end
    if (q.out_full_ch2 && !n.out_full_ch2 && !q.direct_irq_mode) begin
      n.smi_enable_ch2 = 1'b0; // R3
    end
    if (q.out_full_ch3a && !n.out_full_ch3a && !q.direct_irq_mode) begin
      n.irq11_enable_ch3 = 1'b0; // R13
    end

    // LPC hardware or software reset holds all enables at 0
    if (lpc_reset) begin
      n.irq1_enable_ch1 = sie_pkg::SIE_RST_ENABLE; // R9
      n.irq12_enable_ch1 = sie_pkg::SIE_RST_ENABLE; // R6
      n.smi_enable_ch2 = sie_pkg::SIE_RST_ENABLE; // R3
      n.irq11_enable_ch3 = sie_pkg::SIE_RST_ENABLE; // R13
      n.armed = 4'h0;
    end

    // Sticky events; a new event beats a write-one-to-clear in the same cycle
    if (wr_ok && avs_address == sie_pkg::SIE_ADDR_EVT_STATUS) begin
      n.evt_status = q.evt_status & ~wbyte[sie_pkg::SIE_EVT_W-1:0];
    end
    n.evt_status[sie_pkg::SIE_EVT_TAKEN_CH1] = n.evt_status[sie_pkg::SIE_EVT_TAKEN_CH1] || take_ch1;
    n.evt_status[sie_pkg::SIE_EVT_TAKEN_CH2] = n.evt_status[sie_pkg::SIE_EVT_TAKEN_CH2] || take_ch2;
    n.evt_status[sie_pkg::SIE_EVT_TAKEN_CH3] = n.evt_status[sie_pkg::SIE_EVT_TAKEN_CH3] || take_ch3;
    n.evt_status[sie_pkg::SIE_EVT_LPC_RESET] = n.evt_status[sie_pkg::SIE_EVT_LPC_RESET] ||
      lpc_reset;
    n.irq = |(n.evt_status & n.evt_mask);

    // Host interrupt request levels toward the serial interrupt frame engine
    n.req.irq1 = req_level(n.irq1_enable_ch1, 1'b0, n.out_full_ch1); // R8
    n.req.irq12 = req_level(n.irq12_enable_ch1, 1'b0, n.out_full_ch1); // R5
    n.req.smi = req_level(n.smi_enable_ch2, n.direct_irq_mode, n.out_full_ch2); // R1 R2 R15
    n.req.irq11 = req_level(n.irq11_enable_ch3, n.direct_irq_mode, n.out_full_ch3a); // R11 R12
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0; // R16
    end else if (ce) begin
      q <= n;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !((q.bus == sie_pkg::SIE_BUS_ACK) && ce);
  assign avs_readdata = {24'h000000, q.rdata};
  assign host_req = q.req;
  assign host_data = q.data;
  assign irq = q.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_smi_req_gate: assert property (host_req.smi == (q.smi_enable_ch2 && // R15
    (q.direct_irq_mode || q.out_full_ch2)))
    else $error("SMI request disagrees with enable, mode and full flag");
  a_irq12_req_gate: assert property (host_req.irq12 == (q.irq12_enable_ch1 && q.out_full_ch1)) // R5
    else $error("IRQ12 request disagrees with enable and full flag");
  a_irq1_req_gate: assert property (host_req.irq1 == (q.irq1_enable_ch1 && q.out_full_ch1)) // R8
    else $error("IRQ1 request disagrees with enable and full flag");
  a_irq11_direct_req: assert property ((ce && n.irq11_enable_ch3 && n.direct_irq_mode) |=> // R12
    host_req.irq11)
    else $error("IRQ11 not requested in direct mode");
  a_smi_full_clear: assert property ((ce && take_ch2 && !q.direct_irq_mode && // R3
    !(wr_ok && avs_address == sie_pkg::SIE_ADDR_DATA_CH2)) |=> !q.smi_enable_ch2 && !host_req.smi)
    else $error("SMI enable survived full flag drop");
  a_ch1_full_clear: assert property ((ce && q.out_full_ch1 && !n.out_full_ch1) |=> // R6
    !q.irq12_enable_ch1 && !q.irq1_enable_ch1)
    else $error("Channel 1 enables survived full flag drop");
  a_smi_set_armed: assert property ((ce && !q.smi_enable_ch2 && n.smi_enable_ch2) |-> // R4
    q.armed[sie_pkg::SIE_ARM_SMI] && wr_ok)
    else $error("SMI enable set without a prior zero read");
  a_irq11_set_armed: assert property ((ce && !q.irq11_enable_ch3 && n.irq11_enable_ch3) |-> // R14
    q.armed[sie_pkg::SIE_ARM_IRQ11] && wr_ok)
    else $error("IRQ11 enable set without a prior zero read");
  a_lpc_reset_clear: assert property ((ce && lpc_reset) |=> // R16
    !q.irq1_enable_ch1 && !q.irq12_enable_ch1 && !q.smi_enable_ch2 && !q.irq11_enable_ch3)
    else $error("Enable bit survived LPC reset");

  c_host_take_ch1: cover property (ce && take_ch1 && q.irq1_enable_ch1);
  c_smi_direct: cover property (host_req.smi && q.direct_irq_mode && !q.out_full_ch2);
  c_irq11_fullgate: cover property (host_req.irq11 && !q.direct_irq_mode);
  c_evt_irq: cover property ($rose(irq));

endmodule

`default_nettype wire

//--- hdl/sie_pkg.sv
// Constants and carrier types for the host interrupt enable block
package sie_pkg;

  // Register byte offsets
  localparam logic [7:0] SIE_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] SIE_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] SIE_ADDR_DATA_CH1 = 8'h08;
  localparam logic [7:0] SIE_ADDR_DATA_CH2 = 8'h0C;
  localparam logic [7:0] SIE_ADDR_DATA_CH3 = 8'h10;
  localparam logic [7:0] SIE_ADDR_FLAGS = 8'h14;
  localparam logic [7:0] SIE_ADDR_EVT_STATUS = 8'h18;
  localparam logic [7:0] SIE_ADDR_EVT_MASK = 8'h1C;

  // Control 0 fields
  localparam int SIE_BIT_IRQ1_EN = 0;
  localparam int SIE_BIT_IRQ12_EN = 1;
  localparam int SIE_BIT_SMI_EN = 2;
  localparam int SIE_BIT_DIRECT = 5;
  // Control 1 field
  localparam int SIE_BIT_IRQ11_EN = 7;

  // Flags register fields
  localparam int SIE_BIT_FULL_CH1 = 0;
  localparam int SIE_BIT_FULL_CH2 = 1;
  localparam int SIE_BIT_FULL_CH3A = 2;

  // Event status and mask fields
  localparam int SIE_EVT_W = 4;
  localparam int SIE_EVT_TAKEN_CH1 = 0;
  localparam int SIE_EVT_TAKEN_CH2 = 1;
  localparam int SIE_EVT_TAKEN_CH3 = 2;
  localparam int SIE_EVT_LPC_RESET = 3;

  // Arm slots for the read-zero-then-write-one set condition
  localparam int SIE_ARM_IRQ1 = 0;
  localparam int SIE_ARM_IRQ12 = 1;
  localparam int SIE_ARM_SMI = 2;
  localparam int SIE_ARM_IRQ11 = 3;

  // Reset values
  localparam logic SIE_RST_ENABLE = 1'b0;
  localparam logic SIE_RST_FULL = 1'b0;
  localparam logic [7:0] SIE_RST_DATA = 8'h00;
  localparam logic [SIE_EVT_W-1:0] SIE_RST_EVT = 4'h0;

  // Width of the synchronised link bundle
  localparam int SIE_LINK_W = 6;

  typedef enum logic [1:0] {
    SIE_BUS_IDLE = 2'b00,
    SIE_BUS_ACK = 2'b01
  } sie_bus_state_type;

  typedef struct packed {
    logic lpc_clk;
    logic lpc_rst_n;
    logic lpc_swrst;
    logic host_rd_ch1;
    logic host_rd_ch2;
    logic host_rd_ch3;
  } sie_link_type;

  typedef struct packed {
    logic smi;
    logic irq1;
    logic irq12;
    logic irq11;
  } sie_host_req_type;

  typedef struct packed {
    logic [7:0] ch1;
    logic [7:0] ch2;
    logic [7:0] ch3;
  } sie_out_data_type;

endpackage

//--- hdl/sie_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sie_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sie_sync_state_type;

  sie_sync_state_type st_q;
  sie_sync_state_type st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

`default_nettype wire

//--- verif/sie_host_model.sv
// Behavioural LPC host driving the link pins of the enable block
`timescale 1ns/1ps
`default_nettype none

module sie_host_model (
  output sie_pkg::sie_link_type link_pins
);
  // Link clock stands low outside frames
  initial begin
    link_pins = '0;
    link_pins.lpc_rst_n = 1'b1;
  end

  // Host reads one channel: strobe held over three link clock periods
  task automatic take(input int ch);
    link_pins.host_rd_ch1 = (ch == 1);
    link_pins.host_rd_ch2 = (ch == 2);
    link_pins.host_rd_ch3 = (ch == 3);
    #3.3;
    repeat (3) begin
      #62.5 link_pins.lpc_clk = 1'b1;
      #62.5 link_pins.lpc_clk = 1'b0;
    end
    link_pins.host_rd_ch1 = 1'b0;
    link_pins.host_rd_ch2 = 1'b0;
    link_pins.host_rd_ch3 = 1'b0;
    #100;
  endtask

  // Hardware reset when sw is 0, software reset otherwise
  task automatic lpc_reset(input bit sw);
    link_pins.lpc_swrst = sw;
    link_pins.lpc_rst_n = sw;
    #1000;
    link_pins.lpc_swrst = 1'b0;
    link_pins.lpc_rst_n = 1'b1;
    #200;
  endtask
endmodule

`default_nettype wire

//--- verif/sie_host_irq_enable_test.sv
// Self-checking bench for the host interrupt enable block
`timescale 1ns/1ps
`default_nettype none

module sie_host_irq_enable_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  sie_pkg::sie_link_type link_pins;
  sie_pkg::sie_host_req_type host_req;
  sie_pkg::sie_out_data_type host_data;
  int n_fail = 0;
  int total_checks = 0;
  logic [3:0] en = 4'h0;
  logic [2:0] full = 3'h0;
  logic dir = 1'b0;
  logic [7:0] v;

  always #4 clk_sys = ~clk_sys;

  sie_host_irq_enable dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_pins(link_pins), .host_req(host_req),
    .host_data(host_data), .irq(irq));
  sie_host_model host (.link_pins(link_pins));

  function automatic sie_pkg::sie_host_req_type exp_req();
    sie_pkg::sie_host_req_type r;
    r.smi = en[2] & (dir | full[1]);
    r.irq1 = en[0] & full[0];
    r.irq12 = en[1] & full[0];
    r.irq11 = en[3] & (dir | full[2]);
    return r;
  endfunction

  function automatic logic [7:0] ctrl0_exp();
    return {2'h0, dir, 2'h0, en[2:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_req(input sie_pkg::sie_host_req_type got, input sie_pkg::sie_host_req_type exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected request at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask

  task automatic check_all();
    rd(sie_pkg::SIE_ADDR_CTRL0, ctrl0_exp());
    rd(sie_pkg::SIE_ADDR_CTRL1, {en[3], 7'h00});
    rd(sie_pkg::SIE_ADDR_FLAGS, {5'h00, full});
    @(negedge clk_sys);
    chk_req(host_req, exp_req());
  endtask

  // Reads first so that a written one is allowed to set
  task automatic setc(input logic [7:0] c0, input logic c1);
    rd(sie_pkg::SIE_ADDR_CTRL0, ctrl0_exp());
    wr(sie_pkg::SIE_ADDR_CTRL0, c0);
    rd(sie_pkg::SIE_ADDR_CTRL1, {en[3], 7'h00});
    wr(sie_pkg::SIE_ADDR_CTRL1, {c1, 7'h00});
    en = {c1, c0[2:0]};
    dir = c0[5];
    check_all();
  endtask

  task automatic put(input int ch, input logic [7:0] d);
    wr(sie_pkg::SIE_ADDR_DATA_CH1 + 8'(4 * (ch - 1)), d);
    full[ch - 1] = 1'b1;
    @(negedge clk_sys);
    chk(host_data >> (8 * (3 - ch)) & 24'h0000FF, d);
    check_all();
  endtask

  // Host take empties the channel; ch2 and ch3 keep enables in direct mode
  task automatic tk(input int ch);
    host.take(ch);
    full[ch - 1] = 1'b0;
    if (ch == 1) en[1:0] = 2'h0;
    if (ch == 2 && !dir) en[2] = 1'b0;
    if (ch == 3 && !dir) en[3] = 1'b0;
    check_all();
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hA540));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // Ones written without a prior read must not set
    wr(sie_pkg::SIE_ADDR_CTRL0, 8'h07);
    wr(sie_pkg::SIE_ADDR_CTRL1, 8'h80);
    check_all();
    rd(8'h40, 8'h00);
    wr(8'h40, 8'hFF);
    setc(8'h07, 1'b1);
    put(1, 8'($urandom));
    put(2, 8'($urandom));
    tk(1);
    tk(2);
    setc(8'h24, 1'b1);
    put(3, 8'($urandom));
    tk(3);
    setc(8'h20, 1'b0);
    setc(8'h00, 1'b1);
    put(3, 8'($urandom));
    tk(3);
    for (int s = 0; s < 2; s++) begin
      setc(8'h07, 1'b1);
      host.lpc_reset(s[0]);
      en = 4'h0;
      check_all();
    end
    // Clock enable low freezes the bus answer; the write lands once it returns
    @(posedge clk_sys);
    ce <= 1'b0;
    fork
      put(1, 8'h3C);
      begin
        repeat (4) @(posedge clk_sys);
        chk(avs_waitrequest, 1'b1);
        ce <= 1'b1;
      end
    join
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      setc({2'h0, v[4], 2'h0, v[2:0]}, v[3]);
      put(1, v);
      put(2, ~v);
      put(3, v ^ 8'h5A);
      tk(1 + (i % 3));
    end
    setc(8'h00, 1'b0);
    tk(1);
    tk(2);
    tk(3);
    // Status is sticky, mask gates the line, one written clears
    wr(sie_pkg::SIE_ADDR_EVT_STATUS, 8'h0F);
    wr(sie_pkg::SIE_ADDR_EVT_MASK, 8'h00);
    put(1, 8'hA5);
    tk(1);
    rd(sie_pkg::SIE_ADDR_EVT_STATUS, 8'h01);
    chk(irq, 1'b0);
    wr(sie_pkg::SIE_ADDR_EVT_MASK, 8'h01);
    rd(sie_pkg::SIE_ADDR_EVT_MASK, 8'h01);
    chk(irq, 1'b1);
    wr(sie_pkg::SIE_ADDR_EVT_STATUS, 8'h01);
    rd(sie_pkg::SIE_ADDR_EVT_STATUS, 8'h00);
    chk(irq, 1'b0);
    end_sim();
  end
endmodule

`default_nettype wire
